// ---- rtl/vr_supervisor_pkg.sv ----
package vr_supervisor_pkg;

    // Command codes of the settings and the temperature readback
    localparam logic [7:0] CMD_OVERTEMP_FAULT_LIMIT = 8'h51;
    localparam logic [7:0] CMD_OT_ALERT_LIMIT = 8'h52;
    localparam logic [7:0] CMD_TEMP_READBACK = 8'h8d;
    localparam logic [7:0] CMD_MANUFACTURER_CONFIG = 8'hd1;
    localparam logic [7:0] CMD_PG_HIGH_LIMIT = 8'he0;
    localparam logic [7:0] CMD_PG_LOW_LIMIT = 8'he1;
    localparam logic [7:0] CMD_THERMAL_GAIN = 8'hf7;
    localparam logic [7:0] CMD_THERMAL_OFFSET = 8'hf8;

    // Field positions
    localparam int PSI_CODE_LSB = 6;
    localparam int PSI_CODE_MSB = 7;
    localparam int PG_HIGH_MSB = 1;
    localparam int PG_LOW_MSB = 2;

    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_THERMAL_GAIN = 8'h01;
    localparam logic [7:0] RST_OT_FAULT = 8'hff;
    localparam logic [7:0] RST_OT_ALERT = 8'hff;

    // Window and crowbar figures in millivolts
    localparam logic [12:0] PG_HIGH_BASE_MV = 13'h012c;
    localparam logic [12:0] PG_LOW_BASE_MV = 13'h01f4;
    localparam logic [12:0] PG_STEP_MV = 13'h0032;
    localparam logic [12:0] CROWBAR_RELEASE_MV = 13'h012c;

    // Voltage code that means no load is fitted (arbitrary value)
    localparam logic [7:0] NO_CPU_CODE = 8'hff;

    // Timing
    localparam int CLOCK_MHZ = 40;
    localparam int BLANK_TIME_US = 100;
    localparam int BLANK_CYCLES = BLANK_TIME_US * CLOCK_MHZ;

    // Phase masks
    localparam logic [5:0] PHASE_ONE = 6'h01;
    localparam logic [5:0] PHASE_1_4 = 6'h09;
    localparam logic [5:0] PHASE_1_3 = 6'h05;
    localparam logic [5:0] PHASE_1_3_5 = 6'h15;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [7:0] wdata;
    } cmd_req_type;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_RAMP = 2'b01,
        ST_MASK = 2'b10,
        ST_RUN = 2'b11
    } start_state_type;

endpackage

// ---- rtl/vr_supervisor_psi_thermal.sv ----
// Operation
// - Power good low outside window, no-CPU, disabled
// - Blank power-good compare 100 us on change
// - Hold power good until ramp done, delay
// - Reset window is -500 to +300 mV
// - High limit code picks 300 to 150
// - Low limit code picks -500 to -150
// - Low-power input low drives shed disable low
// - Default keeps only phase 1 in low power
// - Low-power phase code in config bits 7:6
// - Six-phase low-power code phase selection
// - Five, four and fewer phase selections
// - Crowbar forces PWM low, release under 300mV
// - Crowbar trip follows power-good high limit
// - Start only with lockout clear, enable high
// - Disabled holds PWM, power good, disables low
// - Hot flag when temperature exceeds fault limit
// - Temperature is voltage times gain plus offset
// - Gain and offset commands; unity gives raw
// - Alert and fault limits, readable temperatures
// - Each code change restarts the blank timer
module vr_supervisor_psi_thermal
    import vr_supervisor_pkg::*;
#(
    parameter int TURNON_DELAY_US = 1000
) (
    input wire logic clock,
    input wire logic reset,
    input wire cmd_req_type cmd_req,
    output logic [7:0] cmd_rdata_q,
    output logic cmd_rvalid_q,
    input wire logic enable_in,
    input wire logic undervoltage_lockout,
    input wire logic [7:0] vid_code,
    input wire logic [12:0] target_mv,
    input wire logic [12:0] current_sense_reference,
    input wire logic ramp_at_target,
    input wire logic low_power_state_n,
    input wire logic [2:0] normal_phases,
    input wire logic [7:0] thermistor_sense,
    output logic power_good_out,
    output logic shed_phase_disable_n,
    output logic core_phase_disable_n,
    output logic regulator_hot_flag,
    output logic temperature_alert,
    output logic crowbar_active,
    output logic [5:0] pwm_enable_q,
    output logic [15:0] temperature_readback
);

    localparam int TURNON_CYCLES = TURNON_DELAY_US * CLOCK_MHZ;

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Window edge in mV from a base and a step code
    function automatic logic [12:0] limit_mv(input logic [12:0] base, input logic [2:0] code);
        limit_mv = base - PG_STEP_MV * {10'h000, code};
    endfunction

    // Phases kept during low power
    function automatic logic [5:0] psi_mask(input logic [2:0] normal, input logic [1:0] code);
        logic [5:0] m;
        m = PHASE_ONE;
        if (normal == 3'h6 && code == 2'h1) m = PHASE_1_4;
        if (normal == 3'h6 && code == 2'h2) m = PHASE_1_3_5;
        if (normal == 3'h5 && code == 2'h1) m = PHASE_1_4;
        if (normal == 3'h4 && code == 2'h1) m = PHASE_1_3;
        psi_mask = m;
    endfunction

    // All phases of normal operation
    function automatic logic [5:0] full_mask(input logic [2:0] normal);
        full_mask = 6'((7'h01 << normal) - 7'h01);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Settings

    logic [7:0] ot_fault_q, ot_alert_q, manufacturer_config_q, pg_high_q, pg_low_q, gain_q, offset_q;
    wire wr = cmd_req.valid && cmd_req.write;
    wire rd = cmd_req.valid && !cmd_req.write;
    logic [7:0] rd_mux;

    // Whole-byte stores replace every bit of the addressed command; the others keep theirs
    always_ff @(posedge clock) begin
        if (reset) begin
            ot_fault_q <= RST_OT_FAULT;
            ot_alert_q <= RST_OT_ALERT;
            manufacturer_config_q <= RST_ZERO;
            pg_high_q <= RST_ZERO;
            pg_low_q <= RST_ZERO;
            gain_q <= RST_THERMAL_GAIN;
            offset_q <= RST_ZERO;
        end else if (wr) begin
            unique case (cmd_req.code)
                CMD_OVERTEMP_FAULT_LIMIT: ot_fault_q <= cmd_req.wdata;
                CMD_OT_ALERT_LIMIT: ot_alert_q <= cmd_req.wdata;
                CMD_MANUFACTURER_CONFIG: manufacturer_config_q <= cmd_req.wdata;
                CMD_PG_HIGH_LIMIT: pg_high_q <= cmd_req.wdata;
                CMD_PG_LOW_LIMIT: pg_low_q <= cmd_req.wdata;
                CMD_THERMAL_GAIN: gain_q <= cmd_req.wdata;
                CMD_THERMAL_OFFSET: offset_q <= cmd_req.wdata;
                default: ;
            endcase
        end
    end

    // Read selection; unknown commands answer zero
    always_comb begin
        unique case (cmd_req.code)
            CMD_OVERTEMP_FAULT_LIMIT: rd_mux = ot_fault_q;
            CMD_OT_ALERT_LIMIT: rd_mux = ot_alert_q;
            CMD_MANUFACTURER_CONFIG: rd_mux = manufacturer_config_q;
            CMD_PG_HIGH_LIMIT: rd_mux = pg_high_q;
            CMD_PG_LOW_LIMIT: rd_mux = pg_low_q;
            CMD_THERMAL_GAIN: rd_mux = gain_q;
            CMD_THERMAL_OFFSET: rd_mux = offset_q;
            CMD_TEMP_READBACK: rd_mux = temperature_readback[7:0];
            default: rd_mux = RST_ZERO;
        endcase
    end

    // Read answer one cycle after the request
    always_ff @(posedge clock) begin
        if (reset) begin
            cmd_rdata_q <= RST_ZERO;
            cmd_rvalid_q <= 1'b0;
        end else begin
            cmd_rdata_q <= rd ? rd_mux : RST_ZERO;
            cmd_rvalid_q <= rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Window and crowbar decode

    wire enabled = enable_in && !undervoltage_lockout;
    wire no_cpu = vid_code == NO_CPU_CODE;
    wire [12:0] high_mv = limit_mv(PG_HIGH_BASE_MV, {1'b0, pg_high_q[PG_HIGH_MSB:0]});
    wire [12:0] low_mv = limit_mv(PG_LOW_BASE_MV, pg_low_q[PG_LOW_MSB:0]);
    wire [13:0] upper_mv = {1'b0, target_mv} + {1'b0, high_mv};
    wire [13:0] sense_ext = {1'b0, current_sense_reference};
    wire too_low = target_mv >= low_mv && // Floor below zero can never be undershot
        {1'b0, current_sense_reference} < {1'b0, target_mv} - {1'b0, low_mv};
    wire in_window = !too_low && sense_ext <= upper_mv;
    // Trip point moves with the programmed high limit
    wire crowbar_trip = sense_ext > upper_mv;
    wire crowbar_release = current_sense_reference < CROWBAR_RELEASE_MV;

    ////////////////////////////////////////////////////////////////////////
    // Turn-on sequence

    start_state_type state_q, state_d;
    logic [23:0] mask_cnt_q;
    wire mask_done = mask_cnt_q == 24'(TURNON_CYCLES - 1);

    // Delay counter only starts once the ramp has arrived
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_OFF: if (enabled) state_d = ST_RAMP;
            ST_RAMP: if (ramp_at_target) state_d = ST_MASK;
            ST_MASK: if (mask_done) state_d = ST_RUN;
            ST_RUN: ;
        endcase
        if (!enabled) state_d = ST_OFF;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= ST_OFF;
            mask_cnt_q <= 24'h000000;
        end else begin
            state_q <= state_d;
            mask_cnt_q <= (state_q == ST_MASK && state_d == ST_MASK) ? mask_cnt_q + 24'h000001 : 24'h000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Blanking after voltage code changes

    logic [7:0] vid_q;
    logic [12:0] blank_cnt_q;
    wire vid_changed = vid_code != vid_q;
    wire blanking = blank_cnt_q != 13'h0000;

    // Every change reloads, so blanking ends after the last one
    always_ff @(posedge clock) begin
        if (reset) begin
            vid_q <= RST_ZERO;
            blank_cnt_q <= 13'h0000;
        end else begin
            vid_q <= vid_code;
            if (vid_changed) blank_cnt_q <= 13'(BLANK_CYCLES);
            else if (blanking) blank_cnt_q <= blank_cnt_q - 13'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Supervisory outputs

    logic pg_d;
    wire [5:0] keep = low_power_state_n ? full_mask(normal_phases) :
        psi_mask(normal_phases, manufacturer_config_q[PSI_CODE_MSB:PSI_CODE_LSB]);
    // Release uses a low floor so the crowbar does not chatter near the trip
    wire crowbar_d = !enabled ? 1'b0 : crowbar_trip ? 1'b1 : crowbar_release ? 1'b0 : crowbar_active;

    // During blanking the last verdict is kept
    always_comb begin
        if (!enabled || no_cpu || state_q != ST_RUN) pg_d = 1'b0;
        else if (blanking) pg_d = power_good_out;
        else pg_d = in_window;
    end

    // All outputs registered so none of them glitch
    always_ff @(posedge clock) begin
        if (reset) begin
            power_good_out <= 1'b0;
            shed_phase_disable_n <= 1'b0;
            core_phase_disable_n <= 1'b0;
            crowbar_active <= 1'b0;
            pwm_enable_q <= 6'h00;
        end else begin
            power_good_out <= pg_d;
            shed_phase_disable_n <= enabled && low_power_state_n;
            core_phase_disable_n <= enabled;
            crowbar_active <= crowbar_d;
            pwm_enable_q <= (enabled && state_q != ST_OFF && !crowbar_d) ? keep : 6'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Thermal channel

    wire [16:0] temp_sum = {1'b0, 16'(thermistor_sense) * 16'(gain_q)} + {9'h000, offset_q};
    wire [15:0] temp_d = temp_sum[16] ? 16'hffff : temp_sum[15:0];

    always_ff @(posedge clock) begin
        if (reset) begin
            temperature_readback <= 16'h0000;
            regulator_hot_flag <= 1'b0;
            temperature_alert <= 1'b0;
        end else begin
            temperature_readback <= temp_d;
            regulator_hot_flag <= temperature_readback > {8'h00, ot_fault_q};
            temperature_alert <= temperature_readback > {8'h00, ot_alert_q};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_ramp_then_wait;
        state_q == ST_RAMP ##1 state_q == ST_MASK;
    endsequence

    property p_pg_disabled;
        !enabled |=> !power_good_out && !core_phase_disable_n && !shed_phase_disable_n && pwm_enable_q == 6'h00;
    endproperty
    a_pg_disabled: assert property (p_pg_disabled) else $error("outputs not low when disabled");

    property p_pg_nocpu;
        no_cpu |=> !power_good_out;
    endproperty
    a_pg_nocpu: assert property (p_pg_nocpu) else $error("power good high on no-CPU code");

    property p_blank_reload;
        vid_changed |=> blank_cnt_q == 13'(BLANK_CYCLES);
    endproperty
    a_blank_reload: assert property (p_blank_reload) else $error("blank timer not reloaded");

    property p_pg_outside;
        state_q == ST_RUN && enabled && !blanking && !in_window |=> !power_good_out;
    endproperty
    a_pg_outside: assert property (p_pg_outside) else $error("power good high outside window");

    property p_pg_turnon;
        s_ramp_then_wait |-> !power_good_out ##1 !power_good_out;
    endproperty
    a_pg_turnon: assert property (p_pg_turnon) else $error("power good before turn-on delay");

    property p_pg_blank_hold;
        state_q == ST_RUN && $past(state_q) == ST_RUN && enabled && !no_cpu && blanking |=> $stable(power_good_out);
    endproperty
    a_pg_blank_hold: assert property (p_pg_blank_hold) else $error("power good moved while blanked");

    property p_shed;
        !low_power_state_n |=> !shed_phase_disable_n;
    endproperty
    a_shed: assert property (p_shed) else $error("shed disable high in low power");

    property p_psi_default;
        !low_power_state_n && manufacturer_config_q[PSI_CODE_MSB:PSI_CODE_LSB] == 2'h0 && !crowbar_d && state_q != ST_OFF &&
            enabled |=> pwm_enable_q == PHASE_ONE;
    endproperty
    a_psi_default: assert property (p_psi_default) else $error("more than phase 1 in low power");

    property p_crowbar;
        enabled && crowbar_trip |=> crowbar_active && pwm_enable_q == 6'h00;
    endproperty
    a_crowbar: assert property (p_crowbar) else $error("PWM not forced low on overvoltage");

    property p_hot;
        temperature_readback > {8'h00, ot_fault_q} && $stable(ot_fault_q) |=> regulator_hot_flag;
    endproperty
    a_hot: assert property (p_hot) else $error("hot flag missing above fault limit");

    property p_high_write;
        wr && cmd_req.code == CMD_PG_HIGH_LIMIT |=> pg_high_q == $past(cmd_req.wdata);
    endproperty
    a_high_write: assert property (p_high_write) else $error("high limit write not applied");

endmodule

// ---- dv/load_model.sv ----
module load_model (
    input wire logic clock,
    input wire logic [5:0] pwm_enable_q,
    input wire logic [12:0] target_mv,
    input wire logic signed [13:0] bias_mv,
    output logic [12:0] current_sense_reference,
    output logic ramp_at_target
);
    timeunit 1ns;
    timeprecision 100ps;
    int sense = 0;
    int goal;

    ////////////////////////////////////////////////////////////
    // Output slews 100 mV a cycle; with every phase held low the load drains it
    initial begin
        current_sense_reference = 13'h0000;
        ramp_at_target = 1'b0;
    end
    always @(posedge clock) begin
        goal = (pwm_enable_q == 6'h00) ? 0 : int'(target_mv) + int'(bias_mv);
        if (sense < goal - 100) begin
            sense = sense + 100;
        end else if (sense > goal + 100) begin
            sense = sense - 100;
        end else begin
            sense = goal;
        end
        current_sense_reference <= #1 13'(sense);
        ramp_at_target <= #1 (sense >= int'(target_mv));
    end
endmodule

// ---- dv/testbench.sv ----
module testbench
    import vr_supervisor_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // Short turn-on mask keeps the run brief
    localparam int TURNON_US = 2;
    localparam int MASK_CYCLES = TURNON_US * CLOCK_MHZ;
    logic clock = 1'b0;
    logic reset = 1'b1;
    cmd_req_type cmd_req = '0;
    logic [7:0] cmd_rdata_q;
    logic cmd_rvalid_q;
    logic enable_in = 1'b0;
    logic undervoltage_lockout = 1'b0;
    logic [7:0] vid_code = 8'h00;
    logic [12:0] target_mv = 13'h04b0;
    logic [12:0] current_sense_reference;
    logic ramp_at_target;
    logic low_power_state_n = 1'b1;
    logic [2:0] normal_phases = 3'h6;
    logic [7:0] thermistor_sense = 8'h00;
    logic power_good_out, shed_phase_disable_n, core_phase_disable_n;
    logic regulator_hot_flag, temperature_alert, crowbar_active;
    logic [5:0] pwm_enable_q;
    logic [15:0] temperature_readback;
    logic signed [13:0] bias_mv = '0;
    int error_cnt = 0;
    int n_tests = 0;
    int cycles = 0;

    ////////////////////////////////////////////////////////////
    vr_supervisor_psi_thermal #(.TURNON_DELAY_US(TURNON_US)) dut_u (.clock(clock), .reset(reset),
        .cmd_req(cmd_req), .cmd_rdata_q(cmd_rdata_q), .cmd_rvalid_q(cmd_rvalid_q), .enable_in(enable_in),
        .undervoltage_lockout(undervoltage_lockout), .vid_code(vid_code), .target_mv(target_mv),
        .current_sense_reference(current_sense_reference), .ramp_at_target(ramp_at_target),
        .low_power_state_n(low_power_state_n), .normal_phases(normal_phases),
        .thermistor_sense(thermistor_sense), .power_good_out(power_good_out),
        .shed_phase_disable_n(shed_phase_disable_n), .core_phase_disable_n(core_phase_disable_n),
        .regulator_hot_flag(regulator_hot_flag), .temperature_alert(temperature_alert),
        .crowbar_active(crowbar_active), .pwm_enable_q(pwm_enable_q),
        .temperature_readback(temperature_readback));
    load_model load_u (.clock(clock), .pwm_enable_q(pwm_enable_q), .target_mv(target_mv), .bias_mv(bias_mv),
        .current_sense_reference(current_sense_reference), .ramp_at_target(ramp_at_target));

    ////////////////////////////////////////////////////////////
    // Clock and hang guard
    always #12.5 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            error_cnt = error_cnt + 1;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////
    // All drives and samples land 2 ns after an edge, clear of the race
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] code, input logic [7:0] data);
        tick(1);
        cmd_req = '{valid: 1'b1, write: 1'b1, code: code, wdata: data};
        tick(1);
        cmd_req = '0;
    endtask
    task automatic rd(input logic [7:0] code, output logic [7:0] data);
        tick(1);
        cmd_req = '{valid: 1'b1, write: 1'b0, code: code, wdata: 8'h00};
        tick(1);
        cmd_req = '0;
        data = cmd_rdata_q;
        check("read strobe", 16'(cmd_rvalid_q), 16'h0001);
    endtask
    task automatic end_test(input string name);
        $display("test %s done, mismatches %0d", name, error_cnt);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Phases kept in low power; table indexed by normal count and code
    function automatic logic [5:0] psi_mask(input int n, input logic [1:0] c);
        if (n == 6 && c == 2'h2) return 6'h15;
        if ((n == 6 || n == 5) && c == 2'h1) return 6'h09;
        if (n == 4 && c == 2'h1) return 6'h05;
        return 6'h01;
    endfunction

    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        static logic [7:0] codes [7] = '{8'h51, 8'hd1, 8'he0, 8'he1, 8'hf7, 8'hf8, 8'h33};
        static logic [7:0] resets [7] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
        logic [7:0] d, r, g, o, lim, alim;
        logic [15:0] t;
        int n;
        void'($urandom(32'h0a689cd6));
        repeat (6) @(posedge clock);
        #2 reset = 1'b0;
        // Reset values, random write and read back; unmapped code reads zero
        foreach (codes[i]) begin
            rd(codes[i], d);
            check("reset value", 16'(d), 16'(resets[i]));
            r = 8'($urandom);
            wr(codes[i], r);
            rd(codes[i], d);
            check("write back", 16'(d), (i == 6) ? 16'h0000 : 16'(r));
            wr(codes[i], resets[i]);
        end
        end_test("registers");
        // Start-up: power good held through ramp and turn-on mask
        enable_in = 1'b1;
        for (n = 0; n < 1000 && ramp_at_target !== 1'b1; n++) tick(1);
        check("pg during ramp", 16'(power_good_out), 16'h0000);
        for (n = 0; n < 1000 && power_good_out !== 1'b1; n++) tick(1);
        check("turn-on hold", 16'(n >= MASK_CYCLES && n <= MASK_CYCLES + 4), 16'h0001);
        check("phases on", 16'({shed_phase_disable_n, core_phase_disable_n, pwm_enable_q}), 16'h00ff);
        end_test("startup");
        // Window edges for every limit code
        for (int c = 0; c < 8; c++) begin
            wr(8'he0, 8'(c % 4));
            wr(8'he1, 8'(c));
            bias_mv = 14'(300 - 50 * (c % 4));
            tick(12);
            check("pg high edge", 16'({power_good_out, crowbar_active}), 16'h0002);
            bias_mv = -14'(500 - 50 * c);
            tick(12);
            check("pg low edge", 16'(power_good_out), 16'h0001);
            bias_mv = bias_mv - 14'sh0001;
            tick(12);
            check("pg below window", 16'(power_good_out), 16'h0000);
        end
        // Crowbar just over the reprogrammed 150 mV limit, release under 300 mV
        bias_mv = 14'sh0097;
        for (n = 0; n < 1000 && crowbar_active !== 1'b1; n++) tick(1);
        tick(1);
        check("crowbar", 16'({pwm_enable_q, power_good_out}), 16'h0000);
        bias_mv = 14'sh0000;
        for (n = 0; n < 1000 && crowbar_active !== 1'b0; n++) tick(1);
        check("release level", 16'(current_sense_reference < 13'h012c), 16'h0001);
        tick(40);
        end_test("window");
        // Low-power phase table over every count and code
        for (int i = 0; i < 24; i++) begin
            n = i / 4 + 1;
            wr(8'hd1, {2'(i), 6'($urandom)});
            normal_phases = 3'(n);
            low_power_state_n = 1'b0;
            tick(4);
            check("low power phases", 16'({shed_phase_disable_n, pwm_enable_q}), 16'(psi_mask(n, 2'(i))));
            low_power_state_n = 1'b1;
            tick(4);
            check("normal phases", 16'({shed_phase_disable_n, pwm_enable_q}), 16'h0040 | 16'((1 << n) - 1));
        end
        normal_phases = 3'h6;
        end_test("low power");
        // Thermal channel; first pass is unity gain, zero offset
        for (int i = 0; i < 16; i++) begin
            g = (i == 0) ? 8'h01 : 8'($urandom);
            o = (i == 0) ? 8'h00 : 8'($urandom);
            lim = 8'($urandom);
            alim = 8'($urandom);
            wr(8'hf7, g);
            wr(8'hf8, o);
            wr(8'h51, lim);
            wr(8'h52, alim);
            thermistor_sense = 8'($urandom);
            tick(4);
            t = 16'(int'(thermistor_sense) * int'(g) + int'(o));
            check("temperature", temperature_readback, t);
            check("hot flags", 16'({regulator_hot_flag, temperature_alert}), 16'({t > 16'(lim), t > 16'(alim)}));
            rd(8'h8d, d);
            check("temperature read", 16'(d), 16'(t[7:0]));
        end
        end_test("thermal");
        // Blanking restarted by a second code change, then the no-load code
        vid_code = 8'h01;
        bias_mv = -14'sh02bc;
        tick(2000);
        check("pg blanked", 16'(power_good_out), 16'h0001);
        vid_code = 8'h02;
        tick(2100);
        check("blank restarted", 16'(power_good_out), 16'h0001);
        tick(2000);
        check("pg after blank", 16'(power_good_out), 16'h0000);
        bias_mv = 14'sh0000;
        tick(20);
        check("pg recovered", 16'(power_good_out), 16'h0001);
        vid_code = 8'hff;
        tick(3);
        check("pg no-load code", 16'(power_good_out), 16'h0000);
        end_test("blanking");
        // Enable low, then lockout with enable high
        enable_in = 1'b0;
        tick(3);
        check("disabled", 16'({power_good_out, shed_phase_disable_n, core_phase_disable_n, pwm_enable_q}), 16'h0000);
        undervoltage_lockout = 1'b1;
        enable_in = 1'b1;
        tick(20);
        check("lockout", 16'({power_good_out, shed_phase_disable_n, core_phase_disable_n, pwm_enable_q}), 16'h0000);
        end_test("disable");
        finish_test();
    end
endmodule
